// file: ssem_pkg.sv
package ssem_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_STAT = 8'h00;
    localparam logic [7:0] OFS_CNT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    // Status and mask bit positions
    localparam int B_FERR = 12;
    localparam int B_BUSY = 11;
    localparam int B_TUR = 8;
    localparam int B_SHIFTER_EMPTY_FLAG = 7;
    localparam int B_ROV = 6;
    localparam int B_RBE = 5;
    localparam int B_TBE = 3;
    localparam int B_TBF = 1;
    localparam int B_RBF = 0;
    localparam int CNT_FIELD = 6;
    localparam logic [15:0] MASK_IMPL = 16'h19EB;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    typedef struct packed {
        logic ignore_overflow;
        logic ignore_underrun;
        logic fifo_mode_select;
        logic port_enable;
    } ssem_ctrl_t;

    localparam ssem_ctrl_t CTRL_RST = 4'h0;

    typedef struct packed {
        logic valid;
        logic wr;
        logic [7:0] addr;
    } ssem_ap_t;
endpackage : ssem_pkg

// file: ssem_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Frame error flag sets on a framing error and holds until software clears it.
// - Activity flag is one while a transaction is in progress, else zero.
// - Underrun flag rises when a word needs transmit data and none is buffered.
// - Underrun flag is cleared whenever the port is disabled.
// - With ignore-underrun, underrun is live status, never halts, needs no clearing.
// - Shifter-empty is one only when neither buffer nor shifter holds transmit data.
// - Overflow flag sets when a whole word arrives while the receive buffer is full.
// - Single buffer: rx empty sets on data port read, clears on word arrival.
// - FIFO mode: rx empty is one exactly when the rx count is zero.
// - Single buffer: tx empty sets when shifter loads, clears on data port write.
// - FIFO mode: tx empty is one exactly when the tx count is zero.
// - Single buffer: tx full sets on data port write, clears when shifter loads.
// - FIFO mode: tx full is one when the tx count is all ones.
// - Single buffer: rx full sets on word arrival, clears on data port read.
// - FIFO mode: rx full is one when the rx count is all ones.
// - Read-only six-bit rx and tx element counts, meaningful in FIFO mode.
// - Count width follows FIFO size: bit 3 from 8, bit 4 from 16, bit 5 at 32.
// - Mask bits gate frame error, activity and underrun onto the event.
// - Mask bits gate shifter-empty and overflow onto the event.
// - Mask bits gate rx empty, tx empty, tx full and rx full onto the event.
// - Ignore-overflow keeps running and keeps contents; otherwise overflow halts the port.
// - A control bit selects FIFO mode (one) or single-buffer mode (zero).
module ssem_top #(
    parameter int FIFO_SIZE_PARAM = 32,
    parameter int WORD_BITS = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Link pins
    input wire logic link_sck_i,
    input wire logic link_sel_n_i,
    // Interrupt event
    output logic event_o
);
    localparam int CW = $clog2(FIFO_SIZE_PARAM) + 1;
    localparam int BW = (WORD_BITS > 1) ? $clog2(WORD_BITS) : 1;
    localparam logic [CW-1:0] CNT_ONES = '1;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [BW-1:0] BIT_LAST = BW'(WORD_BITS - 1);
    localparam logic [BW-1:0] BIT_ZERO = '0;
    localparam logic [1:0] SCK_SYNC_IDLE = 2'h0;
    localparam logic [1:0] SEL_SYNC_IDLE = 2'h3;

    // Offset match on the low address byte, shared by every decode
    function automatic logic ofs_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return (addr == ofs);
    endfunction : ofs_hit

    ssem_pkg::ssem_ctrl_t ctrl;
    ssem_pkg::ssem_ap_t ap;
    logic [15:0] mask;
    logic [1:0] sck_sync;
    logic [1:0] sel_sync;
    logic sck_prev;
    logic sel_prev;
    logic [BW-1:0] bit_cnt;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] rx_cnt;
    logic shift_full;
    logic halted;
    logic frame_error_flag;
    logic tx_underrun_flag;
    logic rx_overflow_flag;
    logic [15:0] stat;
    logic [15:0] rd_val;

    // Link synchronisers; only the second stage is used
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sck_sync <= SCK_SYNC_IDLE;
            sel_sync <= SEL_SYNC_IDLE;
            sck_prev <= 1'b0;
            sel_prev <= 1'b0;
        end else begin
            sck_sync <= {sck_sync[0], link_sck_i};
            sel_sync <= {sel_sync[0], link_sel_n_i};
            sck_prev <= sck_sync[1];
            sel_prev <= ~sel_sync[1];
        end
    end

    logic sck_rise;
    logic sel_act;
    logic active;
    logic word_start;
    logic word_end;
    logic [CW-1:0] cap;
    logic tx_full;
    logic rx_full;
    logic tx_pop;
    logic tx_push;
    logic rx_pop;
    logic rx_push;
    logic under;
    logic ovf;
    logic ferr_ev;
    logic addr_ok;
    logic rd_data;
    logic wr_data;
    logic wr_stat;

    assign sck_rise = sck_sync[1] & ~sck_prev;
    assign sel_act = ~sel_sync[1];
    assign active = ctrl.port_enable & ~halted;
    assign word_start = active & sel_act & sck_rise & (bit_cnt == BIT_ZERO);
    assign word_end = active & sel_act & sck_rise & (bit_cnt == BIT_LAST);
    // Single buffer behaves as a one-deep store
    assign cap = ctrl.fifo_mode_select ? CNT_ONES : CNT_ONE;
    assign tx_full = (tx_cnt == cap);
    assign rx_full = (rx_cnt == cap);
    assign tx_pop = word_start & (tx_cnt != CNT_ZERO);
    assign under = word_start & (tx_cnt == CNT_ZERO);
    assign rx_push = word_end & ~rx_full;
    assign ovf = word_end & rx_full;
    assign ferr_ev = active & sel_prev & ~sel_act & (bit_cnt != BIT_ZERO);

    // AHB address phase
    assign addr_ok = hsel_i & (htrans_i == ssem_pkg::HTRANS_NONSEQ) & hready_i;
    assign rd_data = addr_ok & ~hwrite_i & ofs_hit(haddr_i[7:0], ssem_pkg::OFS_DATA);
    assign wr_data = ap.valid & ap.wr & ofs_hit(ap.addr, ssem_pkg::OFS_DATA);
    assign wr_stat = ap.valid & ap.wr & ofs_hit(ap.addr, ssem_pkg::OFS_STAT);
    assign tx_push = wr_data & ~tx_full;
    assign rx_pop = rd_data & (rx_cnt != CNT_ZERO);

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ap <= '0;
        end else begin
            ap.valid <= addr_ok;
            ap.wr <= hwrite_i;
            ap.addr <= haddr_i[7:0];
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl <= ssem_pkg::CTRL_RST;
            mask <= ssem_pkg::MASK_RST;
        end else if (ap.valid && ap.wr) begin
            if (ofs_hit(ap.addr, ssem_pkg::OFS_CTRL)) begin
                ctrl <= hwdata_i[3:0];
            end else if (ofs_hit(ap.addr, ssem_pkg::OFS_MASK)) begin
                mask <= hwdata_i[15:0] & ssem_pkg::MASK_IMPL;
            end
        end
    end

    // Bit position within a word
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt <= BIT_ZERO;
        end else if (!active || !sel_act) begin
            bit_cnt <= BIT_ZERO;
        end else if (sck_rise) begin
            bit_cnt <= (bit_cnt == BIT_LAST) ? BIT_ZERO : bit_cnt + BW'(1);
        end
    end

    // Transmit shifter occupancy
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_full <= 1'b0;
        end else if (!ctrl.port_enable || !sel_act) begin
            shift_full <= 1'b0;
        end else if (word_start) begin
            shift_full <= tx_pop;
        end else if (word_end) begin
            shift_full <= 1'b0;
        end
    end

    // Element counts
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_cnt <= CNT_ZERO;
            rx_cnt <= CNT_ZERO;
        end else begin
            tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
            rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
        end
    end

    // A critical error stops the port until it is disabled
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            halted <= 1'b0;
        end else if (!ctrl.port_enable) begin
            halted <= 1'b0;
        end else if ((ovf && !ctrl.ignore_overflow) || (under && !ctrl.ignore_underrun)) begin
            halted <= 1'b1;
        end
    end

    // Underrun status
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_underrun_flag <= 1'b0;
        end else if (!ctrl.port_enable) begin
            tx_underrun_flag <= 1'b0;
        end else if (under) begin
            tx_underrun_flag <= 1'b1;
        end else if (ctrl.ignore_underrun && tx_cnt != CNT_ZERO) begin
            tx_underrun_flag <= 1'b0;
        end
    end

    // Sticky error flags; a new event wins over a clear
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_error_flag <= 1'b0;
        end else if (ferr_ev) begin
            frame_error_flag <= 1'b1;
        end else if (wr_stat && !hwdata_i[ssem_pkg::B_FERR]) begin
            frame_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_overflow_flag <= 1'b0;
        end else if (ovf) begin
            rx_overflow_flag <= 1'b1;
        end else if (wr_stat && !hwdata_i[ssem_pkg::B_ROV]) begin
            rx_overflow_flag <= 1'b0;
        end
    end

    // Status word
    always_comb begin
        stat = 16'h0000;
        stat[ssem_pkg::B_FERR] = frame_error_flag;
        stat[ssem_pkg::B_BUSY] = ctrl.port_enable & (sel_act | shift_full);
        stat[ssem_pkg::B_TUR] = tx_underrun_flag;
        stat[ssem_pkg::B_SHIFTER_EMPTY_FLAG] = (tx_cnt == CNT_ZERO) & ~shift_full;
        stat[ssem_pkg::B_ROV] = rx_overflow_flag;
        stat[ssem_pkg::B_RBE] = (rx_cnt == CNT_ZERO);
        stat[ssem_pkg::B_TBE] = (tx_cnt == CNT_ZERO);
        stat[ssem_pkg::B_TBF] = tx_full;
        stat[ssem_pkg::B_RBF] = rx_full;
    end

    // Read decode
    always_comb begin
        rd_val = 16'h0000;
        if (ofs_hit(haddr_i[7:0], ssem_pkg::OFS_STAT)) begin
            rd_val = stat;
        end else if (ofs_hit(haddr_i[7:0], ssem_pkg::OFS_CNT)) begin
            rd_val = {2'h0, ssem_pkg::CNT_FIELD'(rx_cnt), 2'h0, ssem_pkg::CNT_FIELD'(tx_cnt)};
        end else if (ofs_hit(haddr_i[7:0], ssem_pkg::OFS_MASK)) begin
            rd_val = mask;
        end else if (ofs_hit(haddr_i[7:0], ssem_pkg::OFS_CTRL)) begin
            rd_val = {12'h000, ctrl};
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_o <= ssem_pkg::RDATA_RST;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hrdata_o <= (addr_ok && !hwrite_i) ? {16'h0000, rd_val} : ssem_pkg::RDATA_RST;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Event output
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_o <= 1'b0;
        end else begin
            event_o <= |(stat & mask);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_FERR_HOLD: assert property (frame_error_flag && !wr_stat |=> frame_error_flag)
        else $error("frame error flag dropped without a clear");
    AST_BUSY: assert property (ctrl.port_enable && sel_act |-> stat[ssem_pkg::B_BUSY])
        else $error("activity flag low during a transaction");
    AST_TUR_SET: assert property (under && ctrl.port_enable ##1 ctrl.port_enable |-> tx_underrun_flag)
        else $error("underrun not flagged");
    AST_TUR_OFF: assert property (!ctrl.port_enable |=> !tx_underrun_flag)
        else $error("underrun flag set while disabled");
    AST_TUR_LIVE: assert property (ctrl.ignore_underrun && under && !ovf |=> !halted)
        else $error("ignored underrun halted the port");
    AST_SHIFTER_EMPTY_FLAG: assert property (tx_pop |=> !stat[ssem_pkg::B_SHIFTER_EMPTY_FLAG])
        else $error("shifter empty while shifter loaded");
    AST_ROV: assert property (ovf && !ferr_ev |=> rx_overflow_flag && rx_cnt == $past(rx_cnt) - CW'($past(rx_pop)))
        else $error("overflow not flagged or count changed");
    AST_HALT: assert property (ovf && !ctrl.ignore_overflow && ctrl.port_enable ##1 ctrl.port_enable |-> halted)
        else $error("critical overflow did not halt");
    AST_RBE: assert property (rx_pop && rx_cnt == CNT_ONE && !rx_push |=> stat[ssem_pkg::B_RBE])
        else $error("rx empty not set after last read");
    AST_TBF: assert property (tx_push && !tx_pop && tx_cnt + CNT_ONE == cap && $stable(cap) [*1] ##1 $stable(cap)
        |-> stat[ssem_pkg::B_TBF])
        else $error("tx full not set");
    AST_EVENT: assert property (|(stat & mask) |=> event_o)
        else $error("event missing for enabled flag");

    // Buffer flags follow the counts as words move
    AST_TBE_SET: assert property (
        tx_pop && !tx_push && tx_cnt == CNT_ONE |=> stat[ssem_pkg::B_TBE])
        else $error("tx empty not set when the shifter took the last word");
    AST_TBE_CLR: assert property (
        tx_push |=> !stat[ssem_pkg::B_TBE])
        else $error("tx empty still set after a data port write");
    AST_TBF_CLR: assert property (
        tx_pop && !tx_push && tx_full ##1 $stable(cap) |-> !stat[ssem_pkg::B_TBF])
        else $error("tx full still set after the shifter took a word");
    AST_RBF_SET: assert property (
        rx_push && !rx_pop && rx_cnt + CNT_ONE == cap ##1 $stable(cap) |-> stat[ssem_pkg::B_RBF])
        else $error("rx full not set when the buffer filled");
    AST_RBF_CLR: assert property (
        rx_pop && !rx_push && rx_full ##1 $stable(cap) |-> !stat[ssem_pkg::B_RBF])
        else $error("rx full still set after a data port read");
    AST_RBE_CLR: assert property (
        rx_push |=> !stat[ssem_pkg::B_RBE])
        else $error("rx empty still set after a word arrived");
    AST_SHIFTER_EMPTY_FLAG_IDLE: assert property (
        !sel_act && !tx_push && tx_cnt == CNT_ZERO |=> stat[ssem_pkg::B_SHIFTER_EMPTY_FLAG])
        else $error("shifter empty low with nothing to send");

    // Sticky error flags and their clears
    AST_FERR_SET: assert property (
        ferr_ev |=> frame_error_flag)
        else $error("frame error not flagged on a cut word");
    AST_FERR_CLR: assert property (
        wr_stat && !hwdata_i[ssem_pkg::B_FERR] && !ferr_ev |=> !frame_error_flag)
        else $error("frame error flag not cleared by a zero write");
    AST_ROV_HOLD: assert property (
        rx_overflow_flag && !wr_stat |=> rx_overflow_flag)
        else $error("overflow flag dropped without a clear");
    AST_ROV_CLR: assert property (
        wr_stat && !hwdata_i[ssem_pkg::B_ROV] && !ovf |=> !rx_overflow_flag)
        else $error("overflow flag not cleared by a zero write");
    AST_TUR_CLR: assert property (
        ctrl.ignore_underrun && ctrl.port_enable && tx_cnt != CNT_ZERO |=> !tx_underrun_flag)
        else $error("ignored underrun not cleared once data is buffered");
    AST_TUR_HALT: assert property (
        under && !ctrl.ignore_underrun |=> halted)
        else $error("critical underrun did not halt");

    // Halt and event gating
    AST_HALT_KEEP: assert property (
        halted && ctrl.port_enable |=> halted)
        else $error("halt released while the port stays enabled");
    AST_HALT_CLR: assert property (
        !ctrl.port_enable |=> !halted)
        else $error("halt kept while the port is disabled");
    AST_EVENT_OFF: assert property (
        !(|(stat & mask)) |=> !event_o)
        else $error("event raised with no enabled flag");
endmodule : ssem_top

// file: ssem_link_model.sv
`timescale 1ns/100ps
module ssem_link_model (
    // Link pins
    output logic link_sck_o,
    output logic link_sel_n_o
);
    initial begin
        link_sck_o = 1'h0;
        link_sel_n_o = 1'h1;
    end
    // Select moves off the core clock phase
    task automatic sel(input logic act);
        #137 link_sel_n_o = ~act;
        #400;
    endtask : sel
    // Clock stands low outside frames
    task automatic pulses(input int n);
        repeat (n) begin
            #400 link_sck_o = 1'h1;
            #400 link_sck_o = 1'h0;
        end
    endtask : pulses
endmodule : ssem_link_model

// file: ssem_top_test.sv
`timescale 1ns/100ps
module ssem_top_test;
    localparam logic [7:0] ST = ssem_pkg::OFS_STAT;
    localparam logic [7:0] CN = ssem_pkg::OFS_CNT;
    localparam logic [7:0] MK = ssem_pkg::OFS_MASK;
    localparam logic [7:0] CT = ssem_pkg::OFS_CTRL;
    localparam logic [7:0] DA = ssem_pkg::OFS_DATA;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk, rst_n, hsel, hwrite, hready, hresp, event_w, rd_pend, sck, sel_n;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rnd;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [7:0] ofs_q[$];
    int error_cnt = 0;
    int comparisons = 0;

    ssem_top dut_u (
        .core_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .link_sck_i(sck), .link_sel_n_i(sel_n), .event_o(event_w)
    );
    ssem_link_model lnk_u (.link_sck_o(sck), .link_sel_n_o(sel_n));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("Mismatches %0d of %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Single AHB transfer; a read notes its expectation for the monitor
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= {24'h0, ofs};
        htrans <= ssem_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'h0;
        if (wr) hwdata <= d;
        rd_pend <= ~wr;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
            ofs_q.push_back(ofs);
        end
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        rd_pend <= 1'h0;
    endtask : xfer

    task automatic ev(input logic e);
        idle(3);
        @(negedge clk);
        check("event", {31'h0, event_w}, {31'h0, e});
    endtask : ev

    task automatic word(input int n);
        lnk_u.sel(1'h1);
        lnk_u.pulses(n);
        lnk_u.sel(1'h0);
        idle(6);
    endtask : word

    always @(posedge clk) begin
        if (rd_pend === 1'h1) begin
            check("resp", {31'h0, hresp}, 32'h0);
            check("ready", {31'h0, hready}, 32'h1);
            check($sformatf("reg %h", ofs_q.pop_front()), hrdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    initial begin
        idle(6000);
        error_cnt++;
        $display("Error timeout expected finish seen hang");
        wrap_up();
    end

    initial begin
        {hsel, hwrite, rd_pend, rst_n} = 4'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        rnd = $urandom(32'h843213F2);
        idle(12);
        rst_n <= 1'h1;
        xfer(0, ST, 32'h00A8, ALL);
        xfer(0, CN, 32'h0, ALL);
        xfer(0, MK, 32'h0, ALL);
        xfer(0, 8'h14, 32'h0, ALL);
        ev(1'h0);
        rnd = $urandom();
        xfer(1, MK, rnd, ALL);
        xfer(0, MK, {16'h0, rnd[15:0] & ssem_pkg::MASK_IMPL}, ALL);
        xfer(1, MK, 32'h1 << ssem_pkg::B_RBE, ALL);
        ev(1'h1);
        xfer(1, MK, 32'h1 << ssem_pkg::B_FERR, ALL);
        ev(1'h0);
        // Single buffer: one word each way
        xfer(1, CT, 32'h1, ALL);
        xfer(1, DA, $urandom(), ALL);
        xfer(0, ST, 32'h0022, ALL);
        lnk_u.sel(1'h1);
        idle(5);
        xfer(0, ST, 32'h0822, ALL);
        lnk_u.pulses(8);
        idle(6);
        xfer(0, ST, 32'h0889, ALL);
        lnk_u.sel(1'h0);
        idle(5);
        xfer(0, ST, 32'h0089, ALL);
        xfer(0, DA, 32'h0, ALL);
        xfer(0, ST, 32'h00A8, ALL);
        // Live underrun, overflow keeps the held word
        xfer(1, CT, 32'hD, ALL);
        word(8);
        xfer(0, ST, 32'h0189, ALL);
        word(8);
        xfer(0, ST, 32'h01C9, ALL);
        xfer(0, CN, 32'h0100, ALL);
        xfer(0, DA, 32'h0, ALL);
        xfer(0, ST, 32'h01E8, ALL);
        xfer(1, DA, $urandom(), ALL);
        xfer(0, ST, 32'h0062, ALL);
        xfer(1, ST, 32'h0, ALL);
        xfer(0, ST, 32'h0022, ALL);
        // Partial word gives a sticky frame error
        word(3);
        xfer(0, ST, 32'h1000, 32'h1000);
        xfer(1, MK, 32'h1000, ALL);
        ev(1'h1);
        xfer(0, ST, 32'h1000, 32'h1000);
        xfer(1, ST, 32'h0, ALL);
        xfer(0, ST, 32'h0, 32'h1000);
        ev(1'h0);
        // Sticky underrun until the port is disabled
        xfer(1, CT, 32'h1, ALL);
        word(16);
        xfer(0, ST, 32'h0100, 32'h0100);
        xfer(1, DA, $urandom(), ALL);
        xfer(0, ST, 32'h0100, 32'h0100);
        xfer(1, CT, 32'h0, ALL);
        xfer(0, ST, 32'h0, 32'h0100);
        // Critical overflow halts the port; the next word takes no tx data
        xfer(1, CT, 32'h5, ALL);
        word(8);
        word(8);
        xfer(0, ST, 32'h01C9, ALL);
        xfer(1, DA, $urandom(), ALL);
        word(8);
        xfer(0, ST, 32'h0043, ALL);
        // Second reset, then FIFO counts
        @(posedge clk);
        rst_n <= 1'h0;
        idle(2);
        rst_n <= 1'h1;
        xfer(1, CT, 32'hB, ALL);
        repeat (3) xfer(1, DA, $urandom(), ALL);
        xfer(0, CN, 32'h0003, ALL);
        xfer(1, CN, $urandom(), ALL);
        xfer(0, CN, 32'h0003, ALL);
        xfer(0, ST, 32'h0020, 32'h002B);
        word(8);
        xfer(0, CN, 32'h0102, ALL);
        xfer(0, ST, 32'h0000, 32'h002B);
        wrap_up();
    end
endmodule : ssem_top_test
